// ==== rtl/csl_pkg.sv ====
// constants and types shared by the serial link transmitter
//--------------------------------------------------------------------
// What this block does
// - lanes run 8b/10b or 64b/66b, picked by the mode input.
// - 8b/10b output uses plain character stream readable by older receivers.
// - up to eight lanes are enabled by the lane count input.
// - 64b/66b blocks carry a sync header instead of using sync request.
// - sync request low in 8b/10b starts code group synchronization.
// - in 64b/66b the sync request pin only feeds oscillator sync.
// - each sysref event resets the multiframe or multiblock counter.
// - device clock runs all logic and lane serializer words.
// - no command channel is carried in 64b/66b blocks.
// - forward error correction is applied to 64b/66b lane data on enable.
// - no three-bit crc is generated in 64b/66b mode.
// - sync request arrives on a dedicated single-ended input pin.
// - only subclass 1 behaviour, still usable by subclass 0 receivers.
// - all lanes of the link start and align together.
// - no multipoint alignment reference input exists.
// - sync request timing accepts both older handshake revisions.
// - while sync request is low in 8b/10b, every enabled lane sends k28.5 commas.
// - after sync rises, wait multiframe edge, send four k28.0..k28.3 multiframes.
// - 64b/66b always scrambled; 8b/10b optionally; alignment sequence never scrambled.
//--------------------------------------------------------------------
package csl_pkg;
    localparam int CSL_MAX_LANES     = 8;
    localparam int CSL_ILAS_MFRAMES  = 4;
    localparam logic [7:0] CSL_K28_5 = 8'hbc;
    localparam logic [7:0] CSL_K28_0 = 8'h1c;
    localparam logic [7:0] CSL_K28_3 = 8'h7c;
    localparam logic [1:0] CSL_HDR_DATA = 2'h1;
    localparam logic [1:0] CSL_HDR_CTRL = 2'h2;
    localparam logic [14:0] CSL_SCR8_SEED  = 15'h7fff;
    localparam logic [57:0] CSL_SCR64_SEED = 58'h3ff_ffff_ffff_ffff;

    typedef enum logic [1:0] {
        CSL_ST_IDLE = 2'b00,
        CSL_ST_CGS  = 2'b01,
        CSL_ST_ILAS = 2'b11,
        CSL_ST_DATA = 2'b10
    } csl_state_t;
endpackage

// ==== rtl/csl_lane.sv ====
// one lane: scrambler, k-char insert, 64b/66b header and parity
module csl_lane
    import csl_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // control
    input  wire logic        mode_64b66b,
    input  wire logic        scramble_en,
    input  wire logic        fec_en,
    input  wire logic        lane_en,
    input  wire logic        send_k,
    input  wire logic [7:0]  k_char,
    input  wire logic        hdr_ctrl,
    // payload
    input  wire logic [63:0] payload,
    // output word
    output logic [65:0]      lane_word,
    output logic             lane_is_k,
    output logic             lane_parity
);
    logic [14:0] scr8;
    logic [57:0] scr64;
    logic [7:0]  next_octet;
    logic [63:0] next_block;

    // octet scrambler x^15+x^14+1, block scrambler x^58+x^39+1
    always_comb begin
        next_octet = payload[7:0];
        for (int i = 0; i < 8; i++) begin
            next_octet[i] = payload[i] ^ scr8[14 - i] ^ scr8[13 - i];
        end
        next_block = payload;
        for (int i = 0; i < 64; i++) begin
            next_block[i] = payload[i] ^ ((i < 39) ? scr64[38 - i] : 1'b0)
                            ^ ((i < 58) ? scr64[57 - i] : 1'b0);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scr8  <= CSL_SCR8_SEED;
            scr64 <= CSL_SCR64_SEED;
        end else begin
            if (!mode_64b66b && scramble_en && !send_k)
                scr8 <= {scr8[6:0], next_octet};
            if (mode_64b66b)
                scr64 <= next_block[63:6];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lane_word   <= '0;
            lane_is_k   <= 1'b0;
            lane_parity <= 1'b0;
        end else if (!lane_en) begin
            lane_word   <= '0;
            lane_is_k   <= 1'b0;
            lane_parity <= 1'b0;
        end else if (mode_64b66b) begin
            // always scrambled, no command channel, no crc3 bits
            lane_word   <= {next_block, hdr_ctrl ? CSL_HDR_CTRL : CSL_HDR_DATA};
            lane_is_k   <= 1'b0;
            lane_parity <= fec_en ? ^next_block : 1'b0;
        end else if (send_k) begin
            // alignment characters bypass the scrambler
            lane_word   <= {58'h0, k_char};
            lane_is_k   <= 1'b1;
            lane_parity <= 1'b0;
        end else begin
            lane_word   <= {58'h0, scramble_en ? next_octet : payload[7:0]};
            lane_is_k   <= 1'b0;
            lane_parity <= 1'b0;
        end
    end
endmodule

// ==== rtl/csl_tx.sv ====
// top of the multi-lane serial link transmitter
module csl_tx
    import csl_pkg::*;
#(
    parameter int LANES  = CSL_MAX_LANES,
    parameter int MF_LEN = 32
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // configuration
    input  wire logic                mode_64b66b,
    input  wire logic                scramble_en,
    input  wire logic                fec_en,
    input  wire logic [3:0]          lane_count,
    // link control
    input  wire logic                sync_request_single_ended_pin_n,
    input  wire logic                sysref,
    // samples
    input  wire logic [64*LANES-1:0] lane_payload,
    // lanes
    output logic [66*LANES-1:0]      lane_word,
    output logic [LANES-1:0]         lane_is_k,
    output logic [LANES-1:0]         lane_parity,
    output logic                     nco_sync,
    output logic                     link_up,
    output logic                     payload_ready
);
    localparam int MFW = $clog2(MF_LEN);
    localparam logic [MFW-1:0] MF_LAST = MFW'(MF_LEN - 1);

    csl_state_t  state;
    logic [MFW-1:0] mf_cnt;
    logic [1:0]  ilas_cnt;
    logic        sync_q;
    logic        sysref_q;
    logic        mf_edge;
    logic        sync_rise;
    logic [7:0]  k_char;
    logic        send_k;

    //------------------------------------------------------------
    // multiframe counter
    //------------------------------------------------------------
    assign mf_edge   = (mf_cnt == MF_LAST);
    assign sync_rise = sync_request_single_ended_pin_n && !sync_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sysref_q <= 1'b0;
            mf_cnt   <= '0;
        end else begin
            sysref_q <= sysref;
            if (sysref && !sysref_q)
                mf_cnt <= '0;
            else
                mf_cnt <= mf_edge ? '0 : mf_cnt + 1'b1;
        end
    end

    // sync pin sampled directly; each level is acted upon
    always_ff @(posedge core_clk) begin
        if (rst)
            sync_q <= 1'b1;
        else
            sync_q <= sync_request_single_ended_pin_n;
    end

    // 64b/66b passes the pin only to oscillator sync
    assign nco_sync = mode_64b66b && !sync_request_single_ended_pin_n;

    //------------------------------------------------------------
    // link state
    //------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state    <= CSL_ST_IDLE;
            ilas_cnt <= '0;
        end else if (mode_64b66b) begin
            state    <= CSL_ST_DATA;
            ilas_cnt <= '0;
        end else if (!sync_request_single_ended_pin_n) begin
            state    <= CSL_ST_CGS;
            ilas_cnt <= '0;
        end else begin
            case (state)
                CSL_ST_IDLE: state <= CSL_ST_IDLE;
                CSL_ST_CGS: begin
                    if (mf_edge)
                        state <= CSL_ST_ILAS;
                end
                CSL_ST_ILAS: begin
                    if (mf_edge) begin
                        ilas_cnt <= ilas_cnt + 1'b1;
                        if (ilas_cnt == 2'(CSL_ILAS_MFRAMES - 1))
                            state <= CSL_ST_DATA;
                    end
                end
                default: state <= state;
            endcase
        end
    end

    always_comb begin
        send_k = 1'b0;
        k_char = CSL_K28_5;
        if (!mode_64b66b) begin
            if (state == CSL_ST_CGS || state == CSL_ST_IDLE) begin
                send_k = 1'b1;
            end else if (state == CSL_ST_ILAS && mf_cnt == '0) begin
                send_k = 1'b1;
                k_char = CSL_K28_0;
            end else if (state == CSL_ST_ILAS && mf_edge) begin
                send_k = 1'b1;
                k_char = CSL_K28_3;
            end else if (state == CSL_ST_ILAS) begin
                send_k = 1'b1;
                k_char = CSL_K28_5;
            end
        end
    end

    assign link_up       = (state == CSL_ST_DATA);
    assign payload_ready = link_up;

    //------------------------------------------------------------
    // lanes share one state so they align together
    //------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        csl_lane u_lane (
            .core_clk    (core_clk),
            .rst         (rst),
            .mode_64b66b (mode_64b66b),
            .scramble_en (scramble_en || mode_64b66b),
            .fec_en      (fec_en),
            .lane_en     (g < lane_count),
            .send_k      (send_k),
            .k_char      (k_char),
            .hdr_ctrl    (1'b0),
            .payload     (lane_payload[64*g +: 64]),
            .lane_word   (lane_word[66*g +: 66]),
            .lane_is_k   (lane_is_k[g]),
            .lane_parity (lane_parity[g])
        );
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    a_cgs_commas: assert property (@(posedge core_clk) disable iff (rst)
        (!mode_64b66b && !sync_request_single_ended_pin_n) ##1 !mode_64b66b
        |=> lane_is_k[0]) else $error("commas missing during sync request");
    a_sysref_reset: assert property (@(posedge core_clk) disable iff (rst)
        (sysref && !sysref_q) |=> mf_cnt == '0) else $error("sysref did not reset counter");
    a_sync_restart: assert property (@(posedge core_clk) disable iff (rst)
        (!mode_64b66b && !sync_request_single_ended_pin_n) |=> state == CSL_ST_CGS)
        else $error("no restart on sync low");
    a_ilas_start: assert property (@(posedge core_clk) disable iff (rst)
        (state == CSL_ST_CGS && $changed(state) == 0 && !mode_64b66b
         && sync_request_single_ended_pin_n && mf_edge) |=> state == CSL_ST_ILAS)
        else $error("alignment did not start at multiframe edge");
    a_mode_data: assert property (@(posedge core_clk) disable iff (rst)
        mode_64b66b |=> link_up) else $error("64b66b not in data");
    a_nco_only: assert property (@(posedge core_clk) disable iff (rst)
        mode_64b66b ##1 mode_64b66b |-> state == CSL_ST_DATA)
        else $error("sync pin affected 64b66b link");
    a_no_k_64: assert property (@(posedge core_clk) disable iff (rst)
        mode_64b66b ##1 mode_64b66b |-> lane_is_k == '0) else $error("k char in 64b66b");
    a_ilas_len: assert property (@(posedge core_clk) disable iff (rst)
        (state == CSL_ST_ILAS && ilas_cnt == 2'h3 && mf_edge
         && sync_request_single_ended_pin_n && !mode_64b66b) |=> link_up)
        else $error("alignment length wrong");


    //------------------------------------------------------------
    // alignment characters, watched on lane 0
    //------------------------------------------------------------
    // lanes share send_k and k_char, so lane 0 stands for every enabled lane
    a_ilas_open: assert property (@(posedge core_clk) disable iff (rst)
        (state == CSL_ST_ILAS && mf_cnt == '0 && !mode_64b66b
         && lane_count != '0)
        |=> (lane_is_k[0] && lane_word[7:0] == CSL_K28_0))
        else $error("multiframe did not open with start mark");

    a_ilas_close: assert property (@(posedge core_clk) disable iff (rst)
        (state == CSL_ST_ILAS && mf_edge && mf_cnt != '0
         && !mode_64b66b && lane_count != '0)
        |=> (lane_is_k[0] && lane_word[7:0] == CSL_K28_3))
        else $error("multiframe did not close with end mark");

    // payload octets only once the link is up
    a_data_no_k: assert property (@(posedge core_clk) disable iff (rst)
        (state == CSL_ST_DATA && !mode_64b66b)
        |=> lane_is_k == '0)
        else $error("control character in data phase");

    a_link_drop: assert property (@(posedge core_clk) disable iff (rst)
        (!mode_64b66b && !sync_request_single_ended_pin_n)
        |=> !link_up)
        else $error("link stayed up under sync request");

    //------------------------------------------------------------
    // multiframe counter
    //------------------------------------------------------------
    a_cnt_wrap: assert property (@(posedge core_clk) disable iff (rst)
        (mf_edge && !(sysref && !sysref_q))
        |=> mf_cnt == '0)
        else $error("multiframe counter did not wrap");

    a_cnt_step: assert property (@(posedge core_clk) disable iff (rst)
        (!mf_edge && !(sysref && !sysref_q))
        |=> mf_cnt == $past(mf_cnt) + 1'b1)
        else $error("multiframe counter skipped");

    //------------------------------------------------------------
    // lane framing
    //------------------------------------------------------------
    // a disabled lane must stay quiet so the receiver sees no stray commas
    a_lane_off: assert property (@(posedge core_clk) disable iff (rst)
        (lane_count == '0)
        |=> (lane_word[65:0] == '0 && !lane_is_k[0] && !lane_parity[0]))
        else $error("disabled lane not quiet");

    a_hdr_data: assert property (@(posedge core_clk) disable iff (rst)
        (mode_64b66b && lane_count != '0)
        |=> lane_word[1:0] == CSL_HDR_DATA)
        else $error("block header not data");

    // parity bit only exists for blocks
    a_no_parity_8b: assert property (@(posedge core_clk) disable iff (rst)
        !mode_64b66b
        |=> lane_parity == '0)
        else $error("parity bit in 8b10b mode");

    a_nco_8b: assert property (@(posedge core_clk) disable iff (rst)
        !mode_64b66b |-> !nco_sync)
        else $error("oscillator sync in 8b10b mode");

    //------------------------------------------------------------
    // main scenarios
    //------------------------------------------------------------
    c_cgs:  cover property (@(posedge core_clk) state == CSL_ST_CGS);
    c_ilas: cover property (@(posedge core_clk) state == CSL_ST_ILAS);
    c_data: cover property (@(posedge core_clk) link_up && !mode_64b66b);
    c_rise: cover property (@(posedge core_clk) sync_rise && !mode_64b66b);
    c_blk:  cover property (@(posedge core_clk) link_up && mode_64b66b);
endmodule

// ==== tb/csl_rx_model.sv ====
// receiver model: drives the sync request handshake of the 8b/10b link
module csl_rx_model
    import csl_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // bench command: hold the request low
    input  wire logic       req,
    // lane 0 as seen by the receiver
    input  wire logic [7:0] rx_octet,
    input  wire logic       rx_is_k,
    // handshake
    output logic            sync_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic     active;
    int       commas;
    logic     comma_now;

    assign comma_now = rx_is_k && (rx_octet == CSL_K28_5);

    // release only after four commas in a row, as a real receiver would
    always @(posedge core_clk) begin
        if (rst) begin
            active <= 1'b0;
            commas <= 0;
            sync_n <= 1'b1;
        end else if (req) begin
            active <= 1'b1;
            commas <= 0;
            sync_n <= 1'b0;
        end else if (active) begin
            commas <= comma_now ? commas + 1 : 0;
            if (comma_now && commas >= 3) begin
                active <= 1'b0;
                sync_n <= 1'b1;
            end
        end
    end
endmodule

// ==== tb/csl_tx_tb.sv ====
// self-checking bench for the serial link transmitter
module csl_tx_tb;
    import csl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LN = 8;
    localparam int MF = 8;

    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic               mode = 1'b0;
    logic               scr = 1'b1;
    logic               fec = 1'b0;
    logic [3:0]         lane_count = 4'h8;
    logic               sync_n;
    logic               sysref = 1'b0;
    logic               req = 1'b0;
    logic [64*LN-1:0]   payload = {LN{64'h0123_4567_89ab_cdef}};
    logic [66*LN-1:0]   lane_word;
    logic [LN-1:0]      lane_is_k;
    logic [LN-1:0]      lane_parity;
    logic               nco_sync;
    logic               link_up;
    logic               payload_ready;
    int                 err_total = 0;
    int                 tests_run = 0;
    int                 cycles = 0;

    always #10 core_clk = ~core_clk;

    csl_tx #(.LANES(LN), .MF_LEN(MF)) dut (
        .core_clk(core_clk), .rst(rst), .mode_64b66b(mode), .scramble_en(scr),
        .fec_en(fec), .lane_count(lane_count), .sync_request_single_ended_pin_n(sync_n),
        .sysref(sysref), .lane_payload(payload), .lane_word(lane_word),
        .lane_is_k(lane_is_k), .lane_parity(lane_parity), .nco_sync(nco_sync),
        .link_up(link_up), .payload_ready(payload_ready));

    csl_rx_model rx (
        .core_clk(core_clk), .rst(rst), .req(req), .rx_octet(lane_word[7:0]),
        .rx_is_k(lane_is_k[0]), .sync_n(sync_n));

    task automatic chk(input string name, input logic [65:0] seen, input logic [65:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    // bounded wait for a control character on lane 0
    task automatic wait_k(input logic [7:0] v, output int n);
        n = 0;
        do begin
            tick;
            n++;
        end while (!(lane_is_k[0] === 1'b1 && lane_word[7:0] === v) && n < 400);
    endtask

    task automatic t_cgs;
        int n;
        int marks;
        @(posedge core_clk);
        req <= 1'b1;
        repeat (4) tick;
        for (int i = 0; i < LN; i++) begin
            chk("comma", {lane_is_k[i], lane_word[66*i+:8]}, {1'b1, CSL_K28_5});
        end
        chk("link_up in cgs", link_up, 1'b0);
        chk("nco idle in 8b", nco_sync, 1'b0);
        @(posedge core_clk);
        req <= 1'b0;
        #1;
        wait_k(CSL_K28_0, n);
        chk("ilas start seen", n < 400, 1'b1);
        for (int i = 0; i < LN; i++) begin
            chk("lane aligned", {lane_is_k[i], lane_word[66*i+:8]}, {1'b1, CSL_K28_0});
        end
        wait_k(CSL_K28_3, n);
        chk("multiframe length", n, MF - 1);
        marks = 1;
        n = 0;
        while (link_up !== 1'b1 && n < 6 * MF) begin
            tick;
            n++;
            if (lane_is_k[0] === 1'b1 && lane_word[7:0] === CSL_K28_0) marks++;
        end
        chk("ilas multiframes", marks, CSL_ILAS_MFRAMES);
    endtask

    task automatic t_resync;
        int n;
        @(posedge core_clk);
        req <= 1'b1;
        repeat (4) tick;
        chk("link dropped", link_up, 1'b0);
        chk("comma again", {lane_is_k[0], lane_word[7:0]}, {1'b1, CSL_K28_5});
        @(posedge core_clk);
        req <= 1'b0;
        n = 0;
        while (link_up !== 1'b1 && n < 400) begin
            tick;
            n++;
        end
        chk("relink", link_up, 1'b1);
    endtask

    // start of alignment measured from a sysref pulse
    task automatic sref_run(input int d, output int t);
        int n;
        @(posedge core_clk);
        req <= 1'b1;
        sysref <= 1'b1;
        @(posedge core_clk);
        sysref <= 1'b0;
        repeat (d) @(posedge core_clk);
        req <= 1'b0;
        #1;
        wait_k(CSL_K28_0, n);
        t = d + 1 + n;
    endtask

    task automatic t_sysref;
        int t1;
        int t2;
        sref_run(3, t1);
        sref_run(12, t2);
        chk("sysref phase", t1 % MF, t2 % MF);
        // one edge to catch sysref, one for the lane register
        chk("sysref phase abs", t1 % MF, 2);
    endtask

    task automatic t_64b;
        @(posedge core_clk);
        mode <= 1'b1;
        fec <= 1'b1;
        req <= 1'b1;
        repeat (6) tick;
        chk("64b no comma", lane_is_k, '0);
        chk("64b link", link_up, 1'b1);
        chk("payload ready", payload_ready, 1'b1);
        chk("nco sync", nco_sync, 1'b1);
        for (int i = 0; i < LN; i++) begin
            chk("sync header", lane_word[66*i+:2], CSL_HDR_DATA);
            chk("fec parity", lane_parity[i], ^lane_word[66*i+2+:64]);
        end
        @(posedge core_clk);
        req <= 1'b0;
        fec <= 1'b0;
        lane_count <= 4'h4;
        repeat (3) tick;
        chk("parity off", lane_parity, '0);
        for (int i = 4; i < LN; i++) begin
            chk("lane off", lane_word[66*i+:66], '0);
        end
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            results;
        end
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_cgs;
        t_resync;
        t_sysref;
        t_64b;
        results;
    end
endmodule
